/* File: cbx_exec.sv */
// Decode and execute of the branch on carry and the register bit clear instructions.
// Behaviour
// - Carry set loads PC plus twice offset.
// - Target is relative to the following instruction.
// - Taken branch adds one discarded no-operation cycle.
// - Bit clear zeroes one bit, keeps others.
// - Access bit picks access bank or pointer.
// - Extended set, low addresses with access bit clear use indexed offset.
`default_nettype none
module cbx_exec (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic [cbx_pkg::INSTR_W-1:0] instr_word,
  input wire logic [cbx_pkg::PC_W-1:0] pc_next,
  input wire logic carry_flag,
  input wire logic [3:0] bank_select_pointer,
  input wire logic ext_set_en,
  input wire logic [cbx_pkg::DADDR_W-1:0] index_base,
  input wire logic [7:0] rd_data,
  output cbx_pkg::cbx_phase_type phase_r,
  output logic pc_load_r,
  output logic [cbx_pkg::PC_W-1:0] pc_target_r,
  output logic discard_r,
  output logic mem_rd_r,
  output logic mem_wr_r,
  output logic [cbx_pkg::DADDR_W-1:0] mem_addr_r,
  output logic [7:0] mem_wdata_r,
  output logic status_we_r
);
  import cbx_pkg::*;

  // ----------------------------------------------------------------------
  // Phase sequencer
  // ----------------------------------------------------------------------
  cbx_phase_gen u_phase (
    .mclk(mclk),
    .reset_n(reset_n),
    .phase_r(phase_r)
  );

  // ----------------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------------
  cbx_op_type op_r;
  cbx_op_type op_nxt;
  logic [INSTR_W-1:0] ir_r;
  logic take_r;
  wire logic end_q1 = (phase_r == PH_Q1);
  wire logic end_q2 = (phase_r == PH_Q2);
  wire logic end_q3 = (phase_r == PH_Q3);
  wire logic end_q4 = (phase_r == PH_Q4);

  // Recognise the two opcodes from the word presented during Q1.
  wire logic dec_brc = (instr_word[INSTR_W-1:OPC_LSB] == BRC_OPCODE);
  wire logic dec_clr = (instr_word[INSTR_W-1:NIB_LSB] == CLR_NIBBLE);
  // A flushed cycle decodes nothing, so the prefetched word has no effect.
  assign op_nxt = discard_r ? OP_NONE :
                  dec_brc ? OP_BRC :
                  dec_clr ? OP_CLR : OP_NONE;

  // ----------------------------------------------------------------------
  // Operand address for bit clear
  // ----------------------------------------------------------------------
  wire logic [7:0] f_addr = instr_word[FADDR_LSB +: 8];
  wire logic a_bit = instr_word[ABIT_POS];
  wire logic f_low = (f_addr <= ACCESS_SPLIT);
  // Indexed literal offset adds the file address to the index base.
  wire logic [DADDR_W-1:0] idx_addr = DADDR_W'(index_base + {4'h0, f_addr});
  // The access bank maps low addresses to bank 0 and the rest to the top bank.
  wire logic [DADDR_W-1:0] acc_addr = f_low ? {ACCESS_LO_BANK, f_addr} :
                                               {ACCESS_HI_BANK, f_addr};
  wire logic [DADDR_W-1:0] bank_addr = {bank_select_pointer, f_addr};
  wire logic use_idx = !a_bit && ext_set_en && f_low;
  wire logic [DADDR_W-1:0] eff_addr = a_bit ? bank_addr :
                                      use_idx ? idx_addr : acc_addr;

  // ----------------------------------------------------------------------
  // Execute
  // ----------------------------------------------------------------------
  // Sign extend the literal and double it; the PC is already past this word.
  wire logic [7:0] ofs = ir_r[OFS_LSB +: 8];
  wire logic [PC_W-1:0] ofs2 = {{(PC_W-9){ofs[7]}}, ofs, 1'b0};
  wire logic [PC_W-1:0] tgt_nxt = PC_W'(pc_next + ofs2);
  // Clear the selected bit only.
  wire logic [7:0] clr_mask = BIT_ONE << ir_r[BITNUM_LSB +: 3];
  wire logic [7:0] wdata_nxt = rd_data & ~clr_mask;
  wire logic brc_go = (op_r == OP_BRC) && take_r;

  // Instruction register and operation latched at the end of Q1.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      op_r <= OP_NONE;
      ir_r <= INSTR_RESET;
    end else if (end_q1) begin
      op_r <= op_nxt;
      ir_r <= instr_word;
    end
  end

  // Operand read during Q2 for bit clear.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      mem_rd_r <= 1'b0;
      mem_addr_r <= DADDR_RESET;
    end else begin
      mem_rd_r <= end_q1 && (op_nxt == OP_CLR);
      if (end_q1 && (op_nxt == OP_CLR)) begin
        mem_addr_r <= eff_addr;
      end
    end
  end

  // Read carry at the end of Q2 (the literal is latched with the word at the end of Q1); process data there too.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      take_r <= 1'b0;
      mem_wdata_r <= BYTE_RESET;
    end else if (end_q2) begin
      take_r <= carry_flag;
      if (op_r == OP_CLR) begin
        mem_wdata_r <= wdata_nxt;
      end
    end
  end

  // Write strobes stand for the whole of Q4.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      mem_wr_r <= 1'b0;
      pc_load_r <= 1'b0;
      pc_target_r <= PC_RESET;
    end else begin
      mem_wr_r <= end_q3 && (op_r == OP_CLR);
      pc_load_r <= end_q3 && brc_go;
      if (end_q3 && brc_go) begin
        pc_target_r <= tgt_nxt;
      end
    end
  end

  // A taken branch makes the next instruction cycle a discarded no-operation.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      discard_r <= 1'b0;
    end else if (end_q4) begin
      discard_r <= brc_go;
    end
  end

  // Neither instruction writes the arithmetic status flags.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      status_we_r <= 1'b0;
    end else begin
      status_we_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb_ex @(posedge mclk); endclocking
  default disable iff (!reset_n);

  a_brc_carry_cond: assert property (pc_load_r |-> $past(carry_flag, 2))
    else $error("Branch loaded the PC without carry set.");

  a_brc_no_carry: assert property (
    (end_q2 && op_r == OP_BRC && !carry_flag) |-> ##1 !pc_load_r ##1 !pc_load_r)
    else $error("Branch taken with carry clear.");

  a_brc_rel_target: assert property (
    pc_load_r |-> pc_target_r == PC_W'($past(pc_next) +
      {{(PC_W-9){ir_r[7]}}, ir_r[7:0], 1'b0}))
    else $error("Branch target is not next PC plus twice the offset.");

  a_brc_flush_len: assert property (
    $rose(discard_r) |-> discard_r [*4] ##1 !discard_r)
    else $error("Discarded cycle is not exactly one instruction cycle.");

  a_brc_flush_follow: assert property (pc_load_r |=> discard_r)
    else $error("Taken branch did not discard the prefetched word.");

  a_brc_decode_op: assert property (
    (end_q1 && !discard_r && instr_word[15:8] == BRC_OPCODE) |=> op_r == OP_BRC)
    else $error("Carry branch opcode was not decoded.");

  a_clr_bit_value: assert property (
    mem_wr_r |-> mem_wdata_r == ($past(rd_data, 2) & ~(BIT_ONE << ir_r[11:9])))
    else $error("Bit clear wrote a wrong value.");

  a_clr_bank_sel: assert property (
    (mem_rd_r && ir_r[8]) |-> mem_addr_r == {$past(bank_select_pointer), ir_r[7:0]})
    else $error("Banked operand address is wrong.");

  a_clr_access_sel: assert property (
    (mem_rd_r && !ir_r[8] && !$past(ext_set_en)) |->
      mem_addr_r[11:8] == ((ir_r[7:0] <= ACCESS_SPLIT) ? ACCESS_LO_BANK : ACCESS_HI_BANK))
    else $error("Access bank operand address is wrong.");

  a_clr_indexed: assert property (
    (mem_rd_r && !ir_r[8] && $past(ext_set_en) && ir_r[7:0] <= ACCESS_SPLIT) |->
      mem_addr_r == DADDR_W'($past(index_base) + {4'h0, ir_r[7:0]}))
    else $error("Indexed literal offset address is wrong.");

  a_clr_decode_op: assert property (
    (end_q1 && !discard_r && instr_word[15:12] == CLR_NIBBLE) |=>
      op_r == OP_CLR && mem_rd_r)
    else $error("Bit clear opcode was not decoded.");

  a_no_status_wr: assert property (!status_we_r)
    else $error("Status flags were written.");

  a_clr_one_cycle: assert property (mem_wr_r |=> !mem_wr_r ##1 !discard_r)
    else $error("Bit clear took more than one cycle.");

  c_brc_taken: cover property (pc_load_r ##1 discard_r);
  c_brc_not_taken: cover property (end_q2 && op_r == OP_BRC && !carry_flag);
  c_clr_banked: cover property (mem_wr_r && ir_r[8]);
  c_clr_indexed: cover property (mem_rd_r && !ir_r[8] && $past(ext_set_en));
endmodule : cbx_exec
`default_nettype wire

/* File: cbx_phase_gen.sv */
// Four-phase sequencer that splits each instruction cycle into Q1 to Q4.
`default_nettype none
module cbx_phase_gen (
  input wire logic mclk,
  input wire logic reset_n,
  output cbx_pkg::cbx_phase_type phase_r
);
  import cbx_pkg::*;

  cbx_phase_type phase_nxt;

  // Step through the phases in order and wrap after Q4.
  always_comb begin
    unique case (phase_r)
      PH_Q1: phase_nxt = PH_Q2;
      PH_Q2: phase_nxt = PH_Q3;
      PH_Q3: phase_nxt = PH_Q4;
      PH_Q4: phase_nxt = PH_Q1;
    endcase
  end

  // Phase register, starting in Q1 after reset.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      phase_r <= PH_Q1;
    end else begin
      phase_r <= phase_nxt;
    end
  end

  default clocking cb_ph @(posedge mclk); endclocking
  default disable iff (!reset_n);

  a_phase_wrap: assert property (phase_r == PH_Q4 |=> phase_r == PH_Q1)
    else $error("Phase did not wrap to Q1 after Q4.");
endmodule : cbx_phase_gen
`default_nettype wire

/* File: cbx_pkg.sv */
// Constants and types shared by the carry branch and bit clear execute logic.
`default_nettype none
package cbx_pkg;
  // ----------------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------------
  localparam int PC_W = 21;
  localparam int DADDR_W = 12;
  localparam int INSTR_W = 16;
  // ----------------------------------------------------------------------
  // Encodings
  // ----------------------------------------------------------------------
  localparam logic [7:0] BRC_OPCODE = 8'hE2;
  localparam logic [3:0] CLR_NIBBLE = 4'h9;
  localparam logic [7:0] ACCESS_SPLIT = 8'h5F;
  localparam logic [3:0] ACCESS_LO_BANK = 4'h0;
  localparam logic [3:0] ACCESS_HI_BANK = 4'hF;
  localparam logic [7:0] BIT_ONE = 8'h01;
  // ----------------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------------
  localparam int OFS_LSB = 0;
  localparam int FADDR_LSB = 0;
  localparam int ABIT_POS = 8;
  localparam int BITNUM_LSB = 9;
  localparam int OPC_LSB = 8;
  localparam int NIB_LSB = 12;
  // ----------------------------------------------------------------------
  // Reset values and cycle counts
  // ----------------------------------------------------------------------
  localparam logic [PC_W-1:0] PC_RESET = 21'h0_0000;
  localparam logic [DADDR_W-1:0] DADDR_RESET = 12'h000;
  localparam logic [INSTR_W-1:0] INSTR_RESET = 16'h0000;
  localparam logic [7:0] BYTE_RESET = 8'h00;
  localparam int PHASES_PER_CYCLE = 4;
  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {PH_Q1, PH_Q2, PH_Q3, PH_Q4} cbx_phase_type;
  typedef enum logic [1:0] {OP_NONE, OP_BRC, OP_CLR} cbx_op_type;
endpackage : cbx_pkg
`default_nettype wire

/* File: tb.sv */
// Self-checking bench for the carry branch and bit clear execute logic.
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import cbx_pkg::*;
  // ----------------------------------------------------------------------
  // Stimulus and observed signals
  // ----------------------------------------------------------------------
  logic mclk;
  logic reset_n;
  logic [INSTR_W-1:0] instr_word;
  logic [PC_W-1:0] pc_next;
  logic carry_flag;
  logic [3:0] bank_select_pointer;
  logic ext_set_en;
  logic [DADDR_W-1:0] index_base;
  logic [7:0] rd_data;
  cbx_phase_type phase_r;
  logic pc_load_r;
  logic [PC_W-1:0] pc_target_r;
  logic discard_r;
  logic mem_rd_r;
  logic mem_wr_r;
  logic [DADDR_W-1:0] mem_addr_r;
  logic [7:0] mem_wdata_r;
  logic status_we_r;
  int bad_count;
  int n_tests;
  logic [7:0] ofs [5] = '{8'h7F, 8'h80, 8'h00, 8'hFF, 8'h05};
  logic [15:0] odd [5] = '{16'hE300, 16'hE6FF, 16'h8FFF, 16'h0000, 16'hA000};

  cbx_exec dut (.mclk(mclk), .reset_n(reset_n), .instr_word(instr_word), .pc_next(pc_next),
    .carry_flag(carry_flag), .bank_select_pointer(bank_select_pointer),
    .ext_set_en(ext_set_en), .index_base(index_base), .rd_data(rd_data),
    .phase_r(phase_r), .pc_load_r(pc_load_r), .pc_target_r(pc_target_r),
    .discard_r(discard_r), .mem_rd_r(mem_rd_r), .mem_wr_r(mem_wr_r),
    .mem_addr_r(mem_addr_r), .mem_wdata_r(mem_wdata_r), .status_we_r(status_we_r));

  // The clock toggles every half period of 2 ns.
  always #2 mclk = ~mclk;

  // ----------------------------------------------------------------------
  // Comparison, verdict and one instruction with its reference model
  // ----------------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic wrap_up();
    if (bad_count == 0 && n_tests > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : wrap_up

  task automatic run(input logic [15:0] w, input logic [20:0] pc, input logic c,
      input logic [3:0] bsp, input logic ext, input logic [11:0] base, input logic [7:0] rd);
    int k, f, isbc, tk, adr, tgt;
    k = 0;
    while ((phase_r !== PH_Q1 || discard_r !== 1'b0) && k < 16) begin
      @(negedge mclk);
      k++;
    end
    if (k == 16) begin
      bad_count++;
      wrap_up();
    end
    {instr_word, pc_next, carry_flag, bank_select_pointer} = {w, pc, c, bsp};
    {ext_set_en, index_base, rd_data} = {ext, base, rd};
    isbc = (w[15:12] == 4'h9);
    tk = (w[15:8] == 8'hE2) && c;
    f = w[7:0];
    if (w[8]) adr = {bsp, w[7:0]};
    else if (ext && f <= 8'h5F) adr = (base + f) & 12'hFFF;
    else if (f <= 8'h5F) adr = f;
    else adr = 12'hF00 | f;
    tgt = (int'(pc) + 2 * int'($signed(w[7:0]))) & 32'h001F_FFFF;
    @(negedge mclk);
    chk(mem_rd_r, isbc);
    if (isbc) chk(mem_addr_r, adr);
    chk(status_we_r, 0);
    @(negedge mclk);
    chk(mem_rd_r, 0);
    if (isbc) chk(mem_wdata_r, rd & ~(1 << w[11:9]) & 8'hFF);
    @(negedge mclk);
    chk(phase_r, PH_Q4);
    chk(mem_wr_r, isbc);
    chk(pc_load_r, tk);
    if (tk) chk(pc_target_r, tgt);
    @(negedge mclk);
    // A bit clear offered while the fetched word is being thrown away must be ignored.
    for (k = 0; k < 4 && tk; k++) begin
      instr_word = 16'h9E00;
      chk(discard_r, 1);
      chk(mem_rd_r | mem_wr_r | pc_load_r, 0);
      @(negedge mclk);
    end
    chk(discard_r, 0);
  endtask : run

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    int i;
    logic [15:0] w;
    {mclk, reset_n, instr_word, pc_next, carry_flag} = '0;
    {bank_select_pointer, ext_set_en, index_base, rd_data} = '0;
    bad_count = 0;
    n_tests = 0;
    void'($urandom(92004));
    repeat (5) @(posedge mclk);
    @(negedge mclk);
    reset_n = 1'b1;
    for (i = 0; i < 10; i++) begin
      run({8'hE2, ofs[i % 5]}, (i % 5 == 3) ? 21'h0 : 21'($urandom), i < 5, 4'h3, 0, 0, 0);
    end
    for (i = 0; i < 32; i++) begin
      w = {4'h9, 3'(i), 1'(i / 8), (i % 2) ? 8'h60 : 8'h5F};
      run(w, 0, 1, 4'(i), 1'(i / 16), 12'($urandom), (i % 3) ? 8'hFF : 8'($urandom));
    end
    for (i = 0; i < 5; i++) run(odd[i], 21'h1234, 1, 4'h2, 1, 12'h100, 8'hFF);
    for (i = 0; i < 60; i++) begin
      case ($urandom % 3)
        0: w = {8'hE2, 8'($urandom)};
        1: w = {4'h9, 12'($urandom)};
        default: w = 16'($urandom);
      endcase
      run(w, 21'($urandom), 1'($urandom), 4'($urandom), 1'($urandom), 12'($urandom),
        8'($urandom));
    end
    // A reset in the middle of a bit clear drops its strobes and restarts the phases.
    instr_word = 16'h9000;
    @(negedge mclk);
    reset_n = 1'b0;
    #1;
    chk(mem_rd_r, 0);
    chk(phase_r, PH_Q1);
    @(negedge mclk);
    reset_n = 1'b1;
    run(16'hE281, 21'h00_0100, 1, 0, 0, 0, 0);
    wrap_up();
  end
endmodule : tb
`default_nettype wire
